// >>> hw/dpm_consts.svh
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define DPM_CLK_KHZ 10000
`define DPM_SETTLE_MS 5
`define DPM_SETTLE_CYC (`DPM_SETTLE_MS * `DPM_CLK_KHZ)
`define DPM_SLEEP_GAP_MS 120
`define DPM_SLEEP_GAP_CYC (`DPM_SLEEP_GAP_MS * `DPM_CLK_KHZ)
`define DPM_TMR_W 21

// ****************************************
// Command codes
// ****************************************
`define DPM_CMD_SW_RESET 8'h01
`define DPM_CMD_SLEEP_ENTRY 8'h10
`define DPM_CMD_SLEEP_EXIT 8'h11
`define DPM_CMD_NORMAL_DISPLAY 8'h13
`define DPM_CMD_FORCE_BLACK 8'h22
`define DPM_CMD_FORCE_WHITE 8'h23

// ****************************************
// Register byte offsets
// ****************************************
`define DPM_OFS_CMD 12'h000
`define DPM_OFS_STATUS 12'h004
`define DPM_OFS_CTRL 12'h008
`define DPM_OFS_DIAG 12'h00c
`define DPM_OFS_CFG 12'h010

// ****************************************
// Status fields
// ****************************************
`define DPM_ST_AWAKE 0
`define DPM_ST_WAKING 1
`define DPM_ST_NORMAL 2
`define DPM_ST_BLACK 3
`define DPM_ST_WHITE 4
`define DPM_ST_IDLE 5
`define DPM_ST_CMD_IGN 6

// ****************************************
// Control, diagnostic and config fields
// ****************************************
`define DPM_CTRL_IDLE 0
`define DPM_DIAG_LOAD 7
`define DPM_DIAG_FUNC 6
`define DPM_DIAG_CSUM 0
`define DPM_CFG_W 8
`define DPM_CFG_DEFAULT 8'h01

`endif

// >>> hw/dpm_pkg.sv
package dpm_pkg;

  // ****************************************
  // Power states of the block
  // ****************************************
  typedef enum logic [1:0] {
    DPM_ASLEEP = 2'b00,
    DPM_WAKING = 2'b01,
    DPM_AWAKE = 2'b10
  } dpm_power_type;

  // ****************************************
  // Wake sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    DPM_SEQ_IDLE = 2'b00,
    DPM_SEQ_LOAD = 2'b01,
    DPM_SEQ_DIAG = 2'b10,
    DPM_SEQ_SETTLE = 2'b11
  } dpm_seq_type;

endpackage : dpm_pkg

// >>> hw/dpm_seq_if.sv
`timescale 1ns/1ps

interface dpm_seq_if;
  // Control side requests
  logic start;
  logic abort;
  // Sequencer side events
  logic load_pulse;
  logic diag_pulse;
  logic done;
  logic busy;

  modport ctl (output start, output abort, input load_pulse, input diag_pulse, input done,
    input busy);
  modport seq (input start, input abort, output load_pulse, output diag_pulse, output done,
    output busy);
endinterface : dpm_seq_if

// >>> hw/dpm_wake_seq.sv
`timescale 1ns/1ps
`include "dpm_consts.svh"

module dpm_wake_seq #(
  parameter int SETTLE_CYC = `DPM_SETTLE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the command controller
  dpm_seq_if.seq sq
);

  dpm_pkg::dpm_seq_type state_r;
  dpm_pkg::dpm_seq_type state_nxt;
  logic [`DPM_TMR_W-1:0] tmr_r;
  logic [`DPM_TMR_W-1:0] tmr_nxt;
  logic load_r;
  logic diag_r;
  logic done_r;
  wire logic tmr_end;

  // Last cycle of the settle window
  assign tmr_end = (tmr_r == `DPM_TMR_W'(SETTLE_CYC - 1));
  assign sq.load_pulse = load_r;
  assign sq.diag_pulse = diag_r;
  assign sq.done = done_r;
  assign sq.busy = (state_r != dpm_pkg::DPM_SEQ_IDLE);

  // ****************************************
  // Next state: reload, diagnose, settle
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + `DPM_TMR_W'(1);
    case (state_r)
      dpm_pkg::DPM_SEQ_IDLE: begin
        tmr_nxt = '0;
        if (sq.start) begin
          state_nxt = dpm_pkg::DPM_SEQ_LOAD;
        end
      end
      dpm_pkg::DPM_SEQ_LOAD: state_nxt = dpm_pkg::DPM_SEQ_DIAG;
      dpm_pkg::DPM_SEQ_DIAG: state_nxt = dpm_pkg::DPM_SEQ_SETTLE;
      dpm_pkg::DPM_SEQ_SETTLE: begin
        if (tmr_end) begin
          state_nxt = dpm_pkg::DPM_SEQ_IDLE;
        end
      end
      default: state_nxt = dpm_pkg::DPM_SEQ_IDLE;
    endcase
    if (sq.abort) begin
      state_nxt = dpm_pkg::DPM_SEQ_IDLE;
      tmr_nxt = '0;
    end
  end

  // State, timer and event pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= dpm_pkg::DPM_SEQ_IDLE;
      tmr_r <= '0;
      load_r <= 1'b0;
      diag_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      load_r <= (state_nxt == dpm_pkg::DPM_SEQ_LOAD) && !sq.abort;
      diag_r <= (state_nxt == dpm_pkg::DPM_SEQ_DIAG) && !sq.abort;
      done_r <= (state_r == dpm_pkg::DPM_SEQ_SETTLE) && tmr_end && !sq.abort;
    end
  end

endmodule : dpm_wake_seq

// >>> hw/dpm_power_mode.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "dpm_consts.svh"

module dpm_power_mode #(
  parameter int SETTLE_CYC = `DPM_SETTLE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power controls
  output logic dcdc_en,
  output logic osc_en,
  output logic scan_en,
  // Panel image selection
  output logic panel_black,
  output logic panel_white,
  output logic show_frame,
  output logic awake
);

  // ****************************************
  // Declarations
  // ****************************************
  dpm_seq_if sq ();
  // Power and image state
  dpm_pkg::dpm_power_type pwr_r;
  dpm_pkg::dpm_power_type pwr_nxt;
  logic black_r;
  logic black_nxt;
  logic white_r;
  logic white_nxt;
  logic idle_r;
  logic ign_r;
  logic ign_nxt;
  logic [`DPM_CFG_W-1:0] cfg_r;
  logic [7:0] diag_r;
  // Sequencer requests
  logic start_r;
  logic abort_r;
  // APB response flops
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  // Output flops
  logic dcdc_r;
  logic osc_r;
  logic scan_r;
  logic pblack_r;
  logic pwhite_r;
  logic frame_r;
  logic awake_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire logic setup_ph;
  wire logic wr_acc;
  wire logic hit_cmd;
  wire logic hit_status;
  wire logic hit_ctrl;
  wire logic hit_diag;
  wire logic hit_cfg;
  wire logic hit_any;
  wire logic cmd_wr;
  wire logic [7:0] cmd_code;
  wire logic [31:0] status_word;
  wire logic [31:0] rd_word;

  // Address compare on word offset
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a[11:2] == ofs[11:2]);
  endfunction : addr_is

  // Setup phase, write commit and register hits
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
  assign hit_cmd = addr_is(paddr, `DPM_OFS_CMD);
  assign hit_status = addr_is(paddr, `DPM_OFS_STATUS);
  assign hit_ctrl = addr_is(paddr, `DPM_OFS_CTRL);
  assign hit_diag = addr_is(paddr, `DPM_OFS_DIAG);
  assign hit_cfg = addr_is(paddr, `DPM_OFS_CFG);
  assign hit_any = hit_cmd || hit_status || hit_ctrl || hit_diag || hit_cfg;
  assign cmd_wr = wr_acc && hit_cmd;
  assign cmd_code = pwdata[7:0];

  // Image mode and power status word
  assign status_word = {25'h0, ign_r, idle_r, white_r, black_r,
    !(black_r || white_r), (pwr_r == dpm_pkg::DPM_WAKING), (pwr_r == dpm_pkg::DPM_AWAKE)};

  // Read data mux; command register reads as zero
  assign rd_word = hit_status ? status_word :
    hit_ctrl ? {31'h0, idle_r} :
    hit_diag ? {24'h000000, diag_r} :
    hit_cfg ? {24'h000000, cfg_r} : 32'h00000000;

  // ****************************************
  // Command decode
  // ****************************************
  wire logic is_reset;
  wire logic is_entry;
  wire logic is_exit;
  wire logic is_normal;
  wire logic is_black;
  wire logic is_white;
  wire logic in_awake;
  wire logic seq_live;

  // Each decode needs a committed write to the command register
  assign is_reset = cmd_wr && (cmd_code == `DPM_CMD_SW_RESET);
  assign is_entry = cmd_wr && (cmd_code == `DPM_CMD_SLEEP_ENTRY);
  assign is_exit = cmd_wr && (cmd_code == `DPM_CMD_SLEEP_EXIT);
  assign is_normal = cmd_wr && (cmd_code == `DPM_CMD_NORMAL_DISPLAY);
  assign is_black = cmd_wr && (cmd_code == `DPM_CMD_FORCE_BLACK);
  assign is_white = cmd_wr && (cmd_code == `DPM_CMD_FORCE_WHITE);
  assign in_awake = (pwr_r == dpm_pkg::DPM_AWAKE);
  // Pulses count only while waking; abort lags a reset by a cycle
  assign seq_live = (pwr_r == dpm_pkg::DPM_WAKING);

  // ****************************************
  // Power state and image mode next values
  // ****************************************
  always_comb begin
    pwr_nxt = pwr_r;
    black_nxt = black_r;
    white_nxt = white_r;
    ign_nxt = ign_r;
    // Power state moves
    case (pwr_r)
      dpm_pkg::DPM_ASLEEP: begin
        if (is_exit) begin
          pwr_nxt = dpm_pkg::DPM_WAKING;
        end
      end
      dpm_pkg::DPM_WAKING: begin
        if (sq.done) begin
          pwr_nxt = dpm_pkg::DPM_AWAKE;
        end
      end
      dpm_pkg::DPM_AWAKE: begin
        if (is_entry) begin
          pwr_nxt = dpm_pkg::DPM_ASLEEP;
        end
      end
      default: pwr_nxt = dpm_pkg::DPM_ASLEEP;
    endcase
    // Commands other than software reset during the settle window are dropped and flagged
    if (cmd_wr && (pwr_r == dpm_pkg::DPM_WAKING) && !is_reset) begin
      ign_nxt = 1'b1;
    end else if (cmd_wr) begin
      ign_nxt = 1'b0;
    end
    // Forced modes need awake; normal display also acts asleep
    if (pwr_r != dpm_pkg::DPM_WAKING) begin
      if (is_normal) begin
        black_nxt = 1'b0;
        white_nxt = 1'b0;
      end
      if (is_black && in_awake && !black_r) begin
        black_nxt = 1'b1;
        white_nxt = 1'b0;
      end
      if (is_white && in_awake && !white_r) begin
        white_nxt = 1'b1;
        black_nxt = 1'b0;
      end
    end
    // Software reset returns to the reset state from anywhere, except the idle control bit, which keeps its value
    if (is_reset) begin
      pwr_nxt = dpm_pkg::DPM_ASLEEP;
      black_nxt = 1'b0;
      white_nxt = 1'b0;
      ign_nxt = 1'b0;
    end
  end

  // ****************************************
  // Sequencer hookup
  // ****************************************
  // Registered requests; abort follows a software reset
  assign sq.start = start_r;
  assign sq.abort = abort_r;

  dpm_wake_seq #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .sq(sq)
  );

  // Start on sleep exit, abort on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      start_r <= (pwr_r == dpm_pkg::DPM_ASLEEP) && is_exit;
      abort_r <= is_reset;
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  // Power state, forced modes and drop flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= dpm_pkg::DPM_ASLEEP;
      black_r <= 1'b0;
      white_r <= 1'b0;
      ign_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      black_r <= black_nxt;
      white_r <= white_nxt;
      ign_r <= ign_nxt;
    end
  end

  // Idle mode control, software owned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= 1'b0;
    end else if (wr_acc && hit_ctrl) begin
      idle_r <= pwdata[`DPM_CTRL_IDLE];
    end
  end

  // ****************************************
  // Default reload and self-diagnostics
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `DPM_CFG_DEFAULT;
      diag_r <= 8'h00;
    end else if (is_reset) begin
      cfg_r <= `DPM_CFG_DEFAULT;
      diag_r <= 8'h00;
      // Pulses trailing a software reset are dropped
    end else if (sq.load_pulse && seq_live) begin
      cfg_r <= `DPM_CFG_DEFAULT;
      // Loading flag flips when loaded and held values agree
      if (cfg_r == `DPM_CFG_DEFAULT) begin
        diag_r[`DPM_DIAG_LOAD] <= !diag_r[`DPM_DIAG_LOAD];
      end
    end else if (sq.diag_pulse && seq_live) begin
      diag_r[`DPM_DIAG_FUNC] <= !diag_r[`DPM_DIAG_FUNC];
      diag_r[`DPM_DIAG_CSUM] <= (cfg_r != `DPM_CFG_DEFAULT);
    end else if (wr_acc && hit_cfg && (pwr_r != dpm_pkg::DPM_WAKING)) begin
      cfg_r <= pwdata[`DPM_CFG_W-1:0];
    end
  end

  // ****************************************
  // APB response
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      // One access cycle after every setup, no wait states
      pready_r <= setup_ph;
      pslverr_r <= setup_ph && !hit_any;
      // Read data latched at setup, held until the next read
      if (setup_ph && !pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Converter, oscillator and scanning share one enable
  wire logic pwr_on_nxt;

  assign pwr_on_nxt = (pwr_nxt != dpm_pkg::DPM_ASLEEP);

  // Power enables and panel image selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcdc_r <= 1'b0;
      osc_r <= 1'b0;
      scan_r <= 1'b0;
      pblack_r <= 1'b0;
      pwhite_r <= 1'b0;
      frame_r <= 1'b0;
      awake_r <= 1'b0;
    end else begin
      dcdc_r <= pwr_on_nxt;
      osc_r <= pwr_on_nxt;
      scan_r <= pwr_on_nxt;
      pblack_r <= (pwr_nxt == dpm_pkg::DPM_AWAKE) && black_nxt;
      pwhite_r <= (pwr_nxt == dpm_pkg::DPM_AWAKE) && white_nxt;
      frame_r <= (pwr_nxt == dpm_pkg::DPM_AWAKE) && !black_nxt && !white_nxt;
      awake_r <= (pwr_nxt == dpm_pkg::DPM_AWAKE);
    end
  end

  // Ports straight from their flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dcdc_en = dcdc_r;
  assign osc_en = osc_r;
  assign scan_en = scan_r;
  assign panel_black = pblack_r;
  assign panel_white = pwhite_r;
  assign show_frame = frame_r;
  assign awake = awake_r;

endmodule : dpm_power_mode

// >>> bench/dpm_checker.sv
`timescale 1ns/1ps

module dpm_checker #(
  parameter int SETTLE_CYC = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel side
  input wire logic dcdc_en,
  input wire logic osc_en,
  input wire logic scan_en,
  input wire logic panel_black,
  input wire logic panel_white,
  input wire logic show_frame,
  input wire logic awake
);
  // ****
  // Command decode and properties
  // ****
  localparam int WAKE_MAX = SETTLE_CYC + 8;
  wire cmd_wr = psel && penable && pready && pwrite && (paddr[11:2] == 10'h000);
  wire [7:0] code = pwdata[7:0];
  wire to_sleep = cmd_wr && (code == 8'h10 || code == 8'h01);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmd(logic [7:0] c);
    cmd_wr && code == c;
  endsequence
  sequence s_wake;
    dcdc_en ##[1:WAKE_MAX] awake;
  endsequence
  a_pwr_together: assert property (dcdc_en == osc_en && osc_en == scan_en)
    else $error("power enables differ");
  a_asleep_dark: assert property (!dcdc_en |-> !(awake || panel_black || panel_white))
    else $error("panel active while asleep");
  a_exit_wakes: assert property (s_cmd(8'h11) ##0 !dcdc_en |=> s_wake)
    else $error("wake not done in time");
  a_exit_ignored: assert property (s_cmd(8'h11) ##0 awake |=>
    (awake && $stable({panel_black, panel_white, show_frame}))[*3]) else $error("exit changed");
  a_black_set: assert property (s_cmd(8'h22) ##0 awake |-> ##2
    panel_black && !panel_white && !show_frame) else $error("black not set");
  a_white_set: assert property (s_cmd(8'h23) ##0 awake |-> ##2
    panel_white && !panel_black && !show_frame) else $error("white not set");
  a_normal_set: assert property (s_cmd(8'h13) ##0 awake |-> ##2
    show_frame && !panel_black && !panel_white) else $error("normal not set");
  a_stay_awake: assert property (awake && !to_sleep && !$past(to_sleep) |=> awake)
    else $error("awake lost");
  a_black_held: assert property (panel_black && !cmd_wr && !$past(cmd_wr) |=> panel_black)
    else $error("black lost");
  a_white_held: assert property (panel_white && !cmd_wr && !$past(cmd_wr) |=> panel_white)
    else $error("white lost");
  a_sleep_entry: assert property (s_cmd(8'h10) ##0 awake |-> ##[1:3] !dcdc_en)
    else $error("sleep not entered");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready");
endmodule : dpm_checker

bind dpm_power_mode dpm_checker #(.SETTLE_CYC(SETTLE_CYC)) dpm_checker_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dcdc_en, .osc_en,
  .scan_en, .panel_black, .panel_white, .show_frame, .awake);

// >>> bench/dpm_host.sv
`timescale 1ns/1ps

module dpm_host #(
  parameter int GAP_CYC = 30
) (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****
  // Bus cycles and command pacing
  // ****
  int n_tmo = 0;
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
  end
  // One APB transfer, waits for ready
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    int i;
    r = 32'h0000_0000;
    e = 1'b1;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready) begin
        r = prdata;
        e = pslverr;
        break;
      end
    end
    if (i == 16) n_tmo++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Command write with the host-side waits
  task cmd(input logic [7:0] c);
    logic [31:0] r;
    logic e;
    xfer(1'b1, 12'h000, {24'h000000, c}, r, e);
    if (c == 8'h10) repeat (GAP_CYC) @(posedge pclk);
    if (c == 8'h11) begin
      for (int i = 0; i < 200; i++) begin
        xfer(1'b0, 12'h004, 32'h0, r, e);
        if (r[0] === 1'b1) break;
      end
      if (r[0] !== 1'b1) n_tmo++;
    end
  endtask : cmd
endmodule : dpm_host

// >>> bench/dpm_power_mode_tb_top.sv
`timescale 1ns/1ps

module dpm_power_mode_tb_top;
  // ****
  // Clock, reset, design and host
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dcdc_en, osc_en, scan_en, panel_black, panel_white, show_frame, awake;
  int n_errors = 0;
  int total_checks = 0;
  bit m_awake, m_black, m_white, m_idle;
  logic [31:0] r, d0;
  logic e;
  logic [7:0] v;
  logic [7:0] q[$];
  always #50 pclk = ~pclk;
  dpm_power_mode #(.SETTLE_CYC(20)) dpm_power_mode_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dcdc_en, .osc_en, .scan_en,
    .panel_black, .panel_white, .show_frame, .awake);
  dpm_host dpm_host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  // ****
  // Reference model and compares
  // ****
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task model(input logic [7:0] c);
    case (c)
      8'h01: {m_awake, m_black, m_white} = 3'b000;
      8'h10: m_awake = 1'b0;
      8'h11: m_awake = 1'b1;
      8'h13: {m_black, m_white} = 2'b00;
      8'h22: if (m_awake) {m_black, m_white} = 2'b10;
      8'h23: if (m_awake) {m_black, m_white} = 2'b01;
      default: ;
    endcase
  endtask : model
  task chk_state;
    if (dpm_host_i.n_tmo != 0) conclude;
    repeat (3) @(posedge pclk);
    chk("pins", {25'h0, dcdc_en, osc_en, scan_en, awake, panel_black, panel_white, show_frame},
      {25'h0, {4{m_awake}}, m_awake & m_black, m_awake & m_white, m_awake & ~m_black & ~m_white});
    dpm_host_i.xfer(1'b0, 12'h004, 32'h0, r, e);
    chk("status", r & 32'h3d, {26'h0, m_idle, m_white, m_black, ~m_black & ~m_white, 2'b0}
      | {31'h0, m_awake});
  endtask : chk_state
  task conclude;
    n_errors += dpm_host_i.n_tmo;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(32'h2c918ef5));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_state;
    dpm_host_i.xfer(1'b0, 12'h010, 32'h0, r, e);
    chk("cfg", r, 32'h0000_0001);
    dpm_host_i.xfer(1'b0, 12'h0f0, 32'h0, r, e);
    chk("unmapped", {r[30:0], e}, 32'h1);
    dpm_host_i.cmd(8'h22);
    chk_state;
    $display("test reset done");
    v = {1'b1, 7'($urandom)};
    dpm_host_i.xfer(1'b1, 12'h010, {24'h0, v}, r, e);
    dpm_host_i.xfer(1'b0, 12'h00c, 32'h0, d0, e);
    dpm_host_i.xfer(1'b1, 12'h000, 32'h11, r, e);
    dpm_host_i.xfer(1'b1, 12'h000, 32'h22, r, e);
    dpm_host_i.xfer(1'b0, 12'h004, 32'h0, r, e);
    chk("waking", r & 32'h4b, 32'h42);
    dpm_host_i.cmd(8'h11);
    model(8'h11);
    chk_state;
    dpm_host_i.xfer(1'b0, 12'h010, 32'h0, r, e);
    chk("reload", r, 32'h1);
    dpm_host_i.xfer(1'b0, 12'h00c, 32'h0, r, e);
    chk("diag", r, {24'h0, d0[7], ~d0[6], 6'h0});
    dpm_host_i.cmd(8'h10);
    dpm_host_i.cmd(8'h11);
    dpm_host_i.xfer(1'b0, 12'h00c, 32'h0, r, e);
    chk("diag2", r, {24'h0, ~d0[7], d0[6], 6'h0});
    $display("test wake done");
    q = '{8'h11, 8'h22, 8'h22, 8'h23, 8'h23, 8'h13, 8'h13, 8'h22, 8'h10, 8'h11, 8'h01};
    for (int i = 0; i < 24; i++) q.push_back(8'h10 + 8'($urandom % 20));
    foreach (q[i]) begin
      v = q[i];
      if (!(v inside {8'h01, 8'h10, 8'h11, 8'h13, 8'h22, 8'h23})) v = 8'h23;
      m_idle = 1'($urandom);
      dpm_host_i.xfer(1'b1, 12'h008, {31'h0, m_idle}, r, e);
      dpm_host_i.cmd(v);
      model(v);
      chk_state;
    end
    $display("test commands done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {m_awake, m_black, m_white, m_idle} = 4'b0000;
    chk_state;
    $display("test hard reset done");
    conclude;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    conclude;
  end
endmodule : dpm_power_mode_tb_top
